/* File: spw_pkg.sv */
// Purpose: Shared constants and types of the six-output pulse-width modulator.
// Assumes: 32-bit classic Wishbone, byte addresses, one register per aligned word.
// Notes:   Control reset value puts the outputs in H-bridge mode with the high sides off.
`default_nettype none

package spw_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_PAIRS  = 3;
    localparam int unsigned NUM_OUTS   = 6;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned PRESC_W    = 8;
    localparam int unsigned ADR_W      = 8;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] ADR_CONTROL     = 8'h00;
    localparam logic [ADR_W-1:0] ADR_PAIR_BASE   = 8'h04;
    localparam logic [ADR_W-1:0] ADR_PAIR_STRIDE = 8'h10;
    localparam logic [ADR_W-1:0] ADR_PAIR_END    = 8'h34;
    localparam logic [ADR_W-1:0] ADR_TRIP_CLEAR  = 8'h38;
    localparam logic [ADR_W-1:0] ADR_STATUS      = 8'h3C;

    // Word order inside one pair's block of four registers
    localparam logic [1:0] FLD_COMPARE_0 = 2'h0;
    localparam logic [1:0] FLD_COMPARE_1 = 2'h1;
    localparam logic [1:0] FLD_COMPARE_2 = 2'h2;
    localparam logic [1:0] FLD_PERIOD    = 2'h3;

    localparam logic [15:0]      CONTROL_RESET = 16'h0012;
    localparam logic [CNT_W-1:0] CMP_RESET     = 16'h0000;
    localparam logic [CNT_W-1:0] LEN_RESET     = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       spare;                 // bit 15
        logic       sync_enable;           // bit 14
        logic       invert_out5;           // bit 13
        logic       invert_out3;           // bit 12
        logic       invert_out1;           // bit 11
        logic       trip_enable;           // bit 10
        logic       hbridge_output_enable; // bit 9
        logic [2:0] clock_prescale;        // bits 8:6
        logic       invert_all;            // bit 5
        logic       high_side_off;         // bit 4
        logic       load_compare;          // bit 3
        logic       direction;             // bit 2
        logic       hbridge_mode;          // bit 1
        logic       global_output_enable;  // bit 0
    } spw_control_type;

    typedef struct packed {
        logic [CNT_W-1:0] compare_0;
        logic [CNT_W-1:0] compare_1;
        logic [CNT_W-1:0] compare_2;
        logic [CNT_W-1:0] period_length;
    } spw_pair_cfg_type;

    typedef struct packed {
        logic high_side;
        logic low_side;
    } spw_pair_out_type;

endpackage

`default_nettype wire

/* File: spw_pair_timer.sv */
// Purpose: One output pair: 16-bit timer plus edge placement of high and low side.
// Assumes: tick_i is a one-cycle pulse at the prescaled rate.
// Notes:   Compare matches are taken on the count held before each tick.
`default_nettype none

module spw_pair_timer
    import spw_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             tick_i,
    input  wire logic             clear_i,
    input  wire spw_pair_cfg_type cfg_i,
    output spw_pair_out_type      out_o,
    output logic [CNT_W-1:0]      count_o
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             high_side;
        logic             low_side;
    } spw_pair_state_type;

    spw_pair_state_type state_q;
    spw_pair_state_type state_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic hs_next;
        hs_next = state_q.high_side;
        state_d = state_q;
        if (clear_i)
        begin
            state_d.count = '0;
        end
        else if (tick_i)
        begin
            // Period wraps after the count equals the period length
            if (state_q.count == cfg_i.period_length)
                state_d.count = '0;
            else
                state_d.count = state_q.count + CNT_W'(1);
            // Clear after set: equal compares leave the high side low
            if (state_q.count == cfg_i.compare_0)
                hs_next = 1'b1;
            if (state_q.count == cfg_i.compare_1)
                hs_next = 1'b0;
            state_d.high_side = hs_next;
            if (state_q.count == cfg_i.period_length)
                state_d.low_side = 1'b1;
            if (state_q.count == cfg_i.compare_2 || (state_q.high_side && !hs_next))
                state_d.low_side = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign out_o.high_side = state_q.high_side;
    assign out_o.low_side  = state_q.low_side;
    assign count_o         = state_q.count;

endmodule

`default_nettype wire

/* File: spw_top.sv */
// Purpose: Six-output pulse-width modulator in three pairs with H-bridge control.
// Assumes: Classic Wishbone slave, 32-bit data, single clock, synchronous reset.
// Notes:   Sync and trip inputs are taken as synchronous to clk_i.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`default_nettype none

module spw_top
    import spw_pkg::*;
#(
    parameter int unsigned PAIRS = NUM_PAIRS
)
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [31:0]   wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // Pins
    input  wire logic          external_sync_input_i,
    input  wire logic          trip_input_i,
    output logic [NUM_OUTS-1:0] pwm_out_o,
    output logic               trip_irq_o
);

    typedef struct packed {
        spw_control_type                    control;
        spw_pair_cfg_type [NUM_PAIRS-1:0]   pair_cfg;
        logic [PRESC_W-1:0]                 presc;
        logic                               sync_prev;
        logic                               trip_pending;
        logic [NUM_OUTS-1:0]                outs;
        logic                               ack;
        logic [31:0]                        rdata;
    } spw_top_state_type;

    spw_top_state_type state_q;
    spw_top_state_type state_d;

    spw_pair_out_type [NUM_PAIRS-1:0] pair_out;
    logic                             tick;
    logic                             sync_clear;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Prescaler mask: code n gives a divide by 2^(n+1)
    function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] code);
        presc_mask = PRESC_W'((9'h002 << code) - 9'h001);
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [31:0] wdat,
                                               input logic [3:0]  sel);
        lane_merge = old_v;
        if (sel[0])
            lane_merge[7:0] = wdat[7:0];
        if (sel[1])
            lane_merge[15:8] = wdat[15:8];
    endfunction

    function automatic logic is_pair_adr(input logic [ADR_W-1:0] a);
        is_pair_adr = (a >= ADR_PAIR_BASE) && (a < ADR_PAIR_END);
    endfunction

    function automatic logic [1:0] pair_index(input logic [ADR_W-1:0] a);
        logic [ADR_W-1:0] rel;
        rel = a - ADR_PAIR_BASE;
        pair_index = rel[5:4];
    endfunction

    function automatic logic [1:0] pair_field(input logic [ADR_W-1:0] a);
        logic [ADR_W-1:0] rel;
        rel = a - ADR_PAIR_BASE;
        pair_field = rel[3:2];
    endfunction

    // ------------------------------------------------------------
    // Pair timers
    // ------------------------------------------------------------
    assign tick = ((state_q.presc & presc_mask(state_q.control.clock_prescale))
                   == presc_mask(state_q.control.clock_prescale));
    // Sync input is ignored unless enabled
    assign sync_clear = state_q.control.sync_enable && state_q.sync_prev
                        && !external_sync_input_i;

    for (genvar p = 0; p < NUM_PAIRS; p++)
    begin : g_pair
        spw_pair_timer u_pair (
            .clk_i   (clk_i),
            .rst_i   (rst_i),
            .tick_i  (tick),
            .clear_i (sync_clear),
            .cfg_i   (state_q.pair_cfg[p]),
            .out_o   (pair_out[p]),
            .count_o ()
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [ADR_W-1:0]  adr;
        logic              req;
        logic [1:0]        pidx;
        logic [1:0]        pfld;
        logic [NUM_OUTS-1:0] std_outs;
        logic              trip_hit;
        adr      = wb_adr_i[ADR_W-1:0];
        req      = wb_cyc_i && wb_stb_i && !state_q.ack;
        pidx     = pair_index(adr);
        pfld     = pair_field(adr);
        std_outs = '0;
        trip_hit = state_q.control.trip_enable && !trip_input_i;
        state_d  = state_q;

        // Prescaler and sync edge tracking
        state_d.presc     = sync_clear ? '0 : state_q.presc + PRESC_W'(1);
        state_d.sync_prev = external_sync_input_i;

        // Bus: one wait state, ack drops the cycle after it was given
        state_d.ack   = req;
        state_d.rdata = '0;
        if (req && wb_we_i)
        begin
            if (adr == ADR_CONTROL)
                state_d.control = lane_merge(state_q.control, wb_dat_i, wb_sel_i);
            else if (is_pair_adr(adr))
            begin
                case (pfld)
                    FLD_COMPARE_0:
                        state_d.pair_cfg[pidx].compare_0 =
                            lane_merge(state_q.pair_cfg[pidx].compare_0, wb_dat_i, wb_sel_i);
                    FLD_COMPARE_1:
                        state_d.pair_cfg[pidx].compare_1 =
                            lane_merge(state_q.pair_cfg[pidx].compare_1, wb_dat_i, wb_sel_i);
                    FLD_COMPARE_2:
                        state_d.pair_cfg[pidx].compare_2 =
                            lane_merge(state_q.pair_cfg[pidx].compare_2, wb_dat_i, wb_sel_i);
                    default:
                        state_d.pair_cfg[pidx].period_length =
                            lane_merge(state_q.pair_cfg[pidx].period_length, wb_dat_i, wb_sel_i);
                endcase
            end
            else if (adr == ADR_TRIP_CLEAR)
                state_d.trip_pending = 1'b0;
        end
        else if (req)
        begin
            if (adr == ADR_CONTROL)
                state_d.rdata = {16'h0000, state_q.control};
            else if (is_pair_adr(adr))
            begin
                case (pfld)
                    FLD_COMPARE_0: state_d.rdata = {16'h0000, state_q.pair_cfg[pidx].compare_0};
                    FLD_COMPARE_1: state_d.rdata = {16'h0000, state_q.pair_cfg[pidx].compare_1};
                    FLD_COMPARE_2: state_d.rdata = {16'h0000, state_q.pair_cfg[pidx].compare_2};
                    default:       state_d.rdata = {16'h0000,
                                                    state_q.pair_cfg[pidx].period_length};
                endcase
            end
            else if (adr == ADR_STATUS)
                state_d.rdata = {31'h00000000, state_q.trip_pending};
        end

        // Trip beats a same-cycle software write or clear
        if (trip_hit)
        begin
            state_d.control.global_output_enable = 1'b0;
            state_d.trip_pending                 = 1'b1;
        end

        // Standard mapping: pair p drives outputs 2p and 2p+1
        for (int p = 0; p < NUM_PAIRS; p++)
        begin
            std_outs[2*p]   = pair_out[p].high_side;
            std_outs[2*p+1] = pair_out[p].low_side;
        end
        std_outs[1] = std_outs[1] ^ state_q.control.invert_out1;
        std_outs[3] = std_outs[3] ^ state_q.control.invert_out3;
        std_outs[5] = std_outs[5] ^ state_q.control.invert_out5;

        // Output selection; in H-bridge mode high side off is the safe state and overrides all on outputs 3:0
        if (state_q.control.hbridge_mode && state_q.control.high_side_off)
        begin
            state_d.outs      = std_outs & {NUM_OUTS{state_q.control.global_output_enable}};
            state_d.outs[3:0] = 4'h5;
        end
        else if (!state_q.control.global_output_enable)
            state_d.outs = '0;
        else if (state_q.control.hbridge_mode && !state_q.control.hbridge_output_enable)
        begin
            state_d.outs      = std_outs;
            state_d.outs[3:0] = 4'hF;
        end
        else
            state_d.outs = std_outs;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q         <= '0;
            state_q.control <= CONTROL_RESET;
            for (int p = 0; p < NUM_PAIRS; p++)
            begin
                state_q.pair_cfg[p].compare_0     <= CMP_RESET;
                state_q.pair_cfg[p].compare_1     <= CMP_RESET;
                state_q.pair_cfg[p].compare_2     <= CMP_RESET;
                state_q.pair_cfg[p].period_length <= LEN_RESET;
            end
        end
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_dat_o   = state_q.rdata;
    assign wb_ack_o   = state_q.ack;
    assign pwm_out_o  = state_q.outs;
    assign trip_irq_o = state_q.trip_pending;

endmodule

`default_nettype wire

/* File: spw_stage_model.sv */
// Purpose: Power stage on the far side; reports a fault on the trip line.
// Assumes: The bench says when the stage is in fault.
// Notes:   Trip is active low and stands while the fault stands.
`default_nettype none

module spw_stage_model
(
    input  wire logic clk_i,
    input  wire logic fault_i,
    output logic      trip_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // A real comparator reports one cycle late
    always @(posedge clk_i)
        trip_n_o <= !fault_i;
endmodule

`default_nettype wire

/* File: spw_checker_sva.sv */
// Purpose: Port-level checks of the six-output modulator.
// Assumes: Control is written with all byte lanes enabled.
// Notes:   Output checks wait three cycles after a control write or trip.
`default_nettype none

module spw_checker
    import spw_pkg::*;
#(
    parameter int unsigned PAIRS = NUM_PAIRS
)
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [31:0]         wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [31:0]         wb_dat_o,
    input  wire logic                wb_ack_o,
    input  wire logic                external_sync_input_i,
    input  wire logic                trip_input_i,
    input  wire logic [NUM_OUTS-1:0] pwm_out_o,
    input  wire logic                trip_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Shadow of control and settle counters
    // ----------------------------------------
    logic [15:0] ctl_q;
    logic [1:0]  wage_q;
    logic [1:0]  tage_q;
    logic        trip_q;
    logic        wr_ctl;
    logic        trip_ev;
    logic        settle;
    logic        en;

    assign wr_ctl  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[7:0] == ADR_CONTROL;
    assign trip_ev = ctl_q[10] && !trip_input_i;
    assign settle  = wage_q == 2'h3 && tage_q == 2'h3;
    assign en      = ctl_q[0] && !trip_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctl_q  <= 16'h0012;
            wage_q <= 2'h0;
            tage_q <= 2'h3;
            trip_q <= 1'b0;
        end
        else
        begin
            ctl_q  <= wr_ctl ? wb_dat_i[15:0] : ctl_q;
            wage_q <= wr_ctl ? 2'h0 : (wage_q == 2'h3 ? wage_q : wage_q + 2'h1);
            tage_q <= trip_ev ? 2'h0 : (tage_q == 2'h3 ? tage_q : tage_q + 2'h1);
            // Trip beats a same-cycle control write
            trip_q <= trip_ev ? 1'b1 : (wr_ctl ? 1'b0 : trip_q);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_one_wait: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
        else $error("ack did not follow request after one cycle");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_trip_cause: assert property (
        $rose(trip_irq_o) |-> !$past(trip_input_i))
        else $error("trip interrupt rose without trip input");
    a_trip_sets: assert property (
        settle && ctl_q[10] && !trip_input_i ##1 !trip_input_i |=> trip_irq_o)
        else $error("trip low did not raise interrupt");
    a_trip_holds: assert property (
        trip_irq_o && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> trip_irq_o)
        else $error("trip interrupt dropped without a clear write");
    a_high_side_off_forced: assert property (
        settle && ctl_q[1] && ctl_q[4] |-> pwm_out_o[3:0] == 4'h5)
        else $error("high side off did not force outputs");
    a_disabled_off: assert property (
        settle && !en && !(ctl_q[1] && ctl_q[4]) |-> pwm_out_o == 6'h00)
        else $error("outputs active while globally disabled");
    a_bridge_idle: assert property (
        settle && en && ctl_q[1] && !ctl_q[4] && !ctl_q[9] |-> pwm_out_o[3:0] == 4'hF)
        else $error("bridge disable did not set outputs high");
endmodule

bind spw_top spw_checker #(.PAIRS(PAIRS)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_sync_input_i(external_sync_input_i),
    .trip_input_i(trip_input_i), .pwm_out_o(pwm_out_o), .trip_irq_o(trip_irq_o));

`default_nettype wire

/* File: six_channel_pwm_hbridge_tb.sv */
// Purpose: Self-checking bench of the six-output modulator.
// Assumes: One wait state on the register bus.
// Notes:   Counters are resynchronised after each reconfiguration in the edge placement runs.
`default_nettype none

`define CHK(a, e) \
    begin \
        n_compared++; \
        if ((a) !== (e)) \
        begin \
            err_total++; \
            $display("ERROR at %0t got %h exp %h", $time, (a), (e)); \
        end \
    end

module six_channel_pwm_hbridge_tb
    import spw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [31:0] adr   = 32'h0;
    logic [31:0] dat   = 32'h0;
    logic [3:0]  sel   = 4'hF;
    logic        sync  = 1'b1;
    logic        fault = 1'b0;
    logic [31:0] seed  = 32'h0000004A;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic [5:0]  pwm;
    logic        ack;
    logic        irq;
    wire         trip_n;
    int          err_total  = 0;
    int          n_compared = 0;

    spw_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .external_sync_input_i(sync), .trip_input_i(trip_n), .pwm_out_o(pwm),
        .trip_irq_o(irq));
    spw_stage_model stage (.clk_i(clk_i), .fault_i(fault), .trip_n_o(trip_n));

    always #5 clk_i = ~clk_i;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] radr(input int p, input int f);
        return 8'(4 + 16 * p + 4 * f);
    endfunction

    function automatic logic [5:0] inv_exp(input logic [2:0] k);
        return 6'h3D ^ {k[2], 1'b0, k[1], 1'b0, k[0], 1'b0};
    endfunction

    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {24'h0, a};
        dat <= {16'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) err_total++;
    endtask

    task automatic measure(input int i, output logic [31:0] hi, output logic [31:0] per);
        int n;
        n = 0;
        while (pwm[i] !== 1'b0 && n < 5000) begin @(posedge clk_i); n++; end
        while (pwm[i] !== 1'b1 && n < 10000) begin @(posedge clk_i); n++; end
        hi = 0;
        while (pwm[i] === 1'b1 && hi < 5000) begin @(posedge clk_i); hi++; end
        per = hi;
        while (pwm[i] !== 1'b1 && per < 10000) begin @(posedge clk_i); per++; end
    endtask

    task automatic close_out();
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        close_out();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        int p, c, k, len, c0, c1, c2;
        logic [31:0] hi, per;
        logic        saw;
        logic [15:0] mctl [6] = '{16'h0003, 16'h0203, 16'h0002, 16'h0013, 16'h0012, 16'h0201};
        logic [5:0]  mexp [6] = '{6'h3F, 6'h3D, 6'h00, 6'h35, 6'h05, 6'h3D};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(pwm, 6'h05)
        bus(1'b0, ADR_CONTROL, 16'h0);
        `CHK(rd, 32'h0012)
        bus(1'b0, 8'h40, 16'h0);
        `CHK(rd, 32'h0)
        // Upper byte lane alone; this register is rewritten below
        sel <= 4'h2;
        bus(1'b1, radr(1, 2), 16'hABCD);
        sel <= 4'hF;
        bus(1'b0, radr(1, 2), 16'h0);
        `CHK(rd, 32'h0000AB00)
        // Static levels: period 0 keeps the count at 0
        for (p = 0; p < 3; p++)
        begin
            bus(1'b1, radr(p, 1), 16'h0005);
            bus(1'b1, radr(p, 2), p == 0 ? 16'h0000 : 16'h0007);
        end
        for (k = 0; k < 8; k++)
        begin
            bus(1'b1, ADR_CONTROL, 16'h0001 | 16'(k << 11));
            repeat (6) @(posedge clk_i);
            `CHK(pwm, inv_exp(3'(k)))
        end
        for (k = 0; k < 6; k++)
        begin
            bus(1'b1, ADR_CONTROL, mctl[k]);
            repeat (6) @(posedge clk_i);
            `CHK(pwm, mexp[k])
        end
        bus(1'b0, ADR_CONTROL, 16'h0);
        `CHK(rd, 32'h0201)
        // Edge placement over every prescale code, random pair and values
        for (c = 0; c < 8; c++)
        begin
            p   = int'(rnd() % 3);
            len = 4 + int'(rnd() % 4);
            c0  = int'(rnd() % 2);
            c1  = c0 + 1 + int'(rnd() % (len - c0 - 1));
            c2  = c[0] ? 16'hFFFF : int'(rnd() % c1);
            bus(1'b1, radr(p, 0), 16'(c0));
            bus(1'b1, radr(p, 1), 16'(c1));
            bus(1'b1, radr(p, 2), 16'(c2));
            bus(1'b1, radr(p, 3), 16'(len));
            bus(1'b1, ADR_CONTROL, 16'h4001 | 16'(c << 6));
            sync <= 1'b0;
            @(posedge clk_i);
            sync <= 1'b1;
            measure(2 * p, hi, per);
            `CHK(hi, 32'((c1 - c0) << (c + 1)))
            `CHK(per, 32'((len + 1) << (c + 1)))
            measure(2 * p + 1, hi, per);
            `CHK(hi, 32'(((c[0] ? c1 : c2) + 1) << (c + 1)))
        end
        // Frequent sync falls keep the count below compare 0; compare 1 at 1
        // drops a high side left over from earlier runs
        bus(1'b1, radr(0, 0), 16'h0005);
        bus(1'b1, radr(0, 1), 16'h0001);
        bus(1'b1, radr(0, 2), 16'hFFFF);
        bus(1'b1, radr(0, 3), 16'h000A);
        for (c = 0; c < 2; c++)
        begin
            bus(1'b1, ADR_CONTROL, c == 0 ? 16'h4001 : 16'h0001);
            saw = 1'b0;
            for (k = 0; k < 240; k++)
            begin
                @(posedge clk_i);
                sync <= k[2];
                if (k > 40) saw = saw | (pwm[0] === 1'b1);
            end
            `CHK(saw, c == 1)
        end
        // Trip, then clear
        bus(1'b1, ADR_CONTROL, 16'h0401);
        // Let the checker settle so the trip assertion is armed
        repeat (4) @(posedge clk_i);
        fault <= 1'b1;
        repeat (5) @(posedge clk_i);
        fault <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(irq, 1'b1)
        `CHK(pwm, 6'h00)
        bus(1'b0, ADR_STATUS, 16'h0);
        `CHK(rd, 32'h1)
        bus(1'b0, ADR_CONTROL, 16'h0);
        `CHK(rd, 32'h0400)
        bus(1'b1, ADR_TRIP_CLEAR, 16'hA5A5);
        repeat (3) @(posedge clk_i);
        `CHK(irq, 1'b0)
        bus(1'b1, ADR_CONTROL, 16'h0001);
        fault <= 1'b1;
        repeat (5) @(posedge clk_i);
        fault <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(irq, 1'b0)
        close_out();
    end
endmodule

`default_nettype wire
